// *** hw/ssr_core.sv ***
`timescale 1ns/100ps
// Store and recall manager for operating states and sweep elements
module ssr_core
    import ssr_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                resetn,
    input  wire logic                req_valid,
    input  wire ssr_pkg::ssr_cmd_t   req_cmd,
    input  wire logic [3:0]          req_slot,
    input  wire logic [6:0]          req_elem,
    input  wire logic [63:0]         cur_state_in,
    input  wire logic [95:0]         cur_elem_in,
    input  wire logic                mode_changed,
    input  wire logic                shift_key,
    input  wire logic                save_switch,
    output logic                     req_ready,
    output logic                     done,
    output logic [7:0]               error_code,
    output logic                     state_load,
    output logic [63:0]              state_out,
    output logic                     elem_load,
    output logic [95:0]              elem_out
);
    import ssr_pkg::*;

    typedef enum logic [5:0]
    {
        ST_INIT = 6'h01,
        ST_CLR  = 6'h02,
        ST_BOOT = 6'h04,
        ST_IDLE = 6'h08,
        ST_RD   = 6'h10,
        ST_OUT  = 6'h20
    } ssr_st_t;

    typedef struct packed
    {
        ssr_st_t            st;
        logic [1:0]         sh_sync;
        logic [1:0]         sw_sync;
        logic [6:0]         n_elem;
        logic [6:0]         ptr;
        logic               rd_elem;
        logic               clr_boot;
        logic               done;
        logic [7:0]         err;
        logic               sload;
        logic [63:0]        sout;
        logic               eload;
        logic [95:0]        eout;
    } ssr_regs_t;

    ssr_regs_t r, nxt;

    logic               s_we, e_we;
    logic [3:0]         s_wa, s_ra;
    logic [5:0]         e_wa, e_ra;
    logic [63:0]        s_wd, s_rd;
    logic [95:0]        e_wd, e_rd;
    logic [3:0]         map_slot, low_slot;
    logic [5:0]         last_elem;

    ssr_elem_map u_map
    (
        .elem_idx  (last_elem),
        .elem_slot (map_slot)
    );

    // State slots; elements keep a memory of their own
    ssr_mem #(.AW(4), .DW(64), .DEPTH(10)) u_state_mem
    (
        .sys_clk (sys_clk),
        .wr_en   (s_we),
        .wr_addr (s_wa),
        .wr_data (s_wd),
        .rd_addr (s_ra),
        .rd_data (s_rd)
    );

    ssr_mem #(.AW(6), .DW(96), .DEPTH(63)) u_elem_mem
    (
        .sys_clk (sys_clk),
        .wr_en   (e_we),
        .wr_addr (e_wa),
        .wr_data (e_wd),
        .rd_addr (e_ra),
        .rd_data (e_rd)
    );

    // Lowest slot in use holds the last stored element; ten means none
    assign last_elem = 6'(r.n_elem - 7'h01);
    assign low_slot  = (r.n_elem == 7'h00) ? NUM_SLOTS : map_slot;
    assign req_ready = (r.st == ST_IDLE);

    // Next-state logic for the whole block
    always_comb
    begin
        nxt = r;
        nxt.sh_sync = {r.sh_sync[0], shift_key};
        nxt.sw_sync = {r.sw_sync[0], save_switch};
        nxt.done = 1'b0;
        nxt.sload = 1'b0;
        nxt.eload = 1'b0;
        s_we = 1'b0;
        e_we = 1'b0;
        s_wa = req_slot;
        s_wd = cur_state_in;
        e_wa = req_elem[5:0];
        e_wd = cur_elem_in;
        s_ra = req_slot;
        e_ra = req_elem[5:0];
        unique case (r.st)
            // Wait for synchronised straps before deciding
            ST_INIT:
            begin
                nxt.ptr = r.ptr + 7'h01;
                if (r.ptr[1])
                begin
                    nxt.ptr = '0;
                    nxt.clr_boot = 1'b1;
                    if (r.sh_sync[1])
                        nxt.st = ST_CLR;
                    else
                        nxt.st = ST_BOOT;
                end
            end
            // Clear presets slots from ptr to slot 9; memory clear starts at slot 0
            ST_CLR:
            begin
                s_we = (r.ptr < 7'(NUM_SLOTS));
                s_wa = r.ptr[3:0];
                s_wd = PRESET_STATE;
                nxt.n_elem = '0;
                nxt.ptr = r.ptr + 7'h01;
                if (r.ptr == 7'(NUM_SLOTS))
                begin
                    // An element clear must not reload the power-on state
                    if (r.clr_boot)
                        nxt.st = ST_BOOT;
                    else
                    begin
                        nxt.done = 1'b1;
                        nxt.st = ST_IDLE;
                    end
                end
            end
            // Choose power-on state from slot 0 or default
            ST_BOOT:
            begin
                s_ra = '0;
                nxt.rd_elem = 1'b0;
                if (r.sw_sync[1])
                    nxt.st = ST_RD;
                else
                begin
                    nxt.sload = 1'b1;
                    nxt.sout = PRESET_STATE;
                    nxt.st = ST_IDLE;
                end
            end
            // Every taken request is answered; a refusal writes nothing
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    nxt.done = 1'b1;
                    nxt.err = ERR_NONE;
                    unique case (req_cmd)
                        CMD_SAVE, CMD_PDOWN:
                        begin
                            if (req_cmd == CMD_PDOWN)
                                s_wa = '0;
                            if (req_cmd == CMD_SAVE &&
                                (req_slot > TOP_SLOT ||
                                 (req_slot > low_slot &&
                                  low_slot != NUM_SLOTS)))
                                nxt.err = ERR_RANGE_23;
                            else
                            begin
                                s_we = 1'b1;
                                if (req_cmd == CMD_SAVE &&
                                    req_slot == low_slot)
                                    nxt.n_elem = 7'(TOP_SLOT - low_slot)
                                        * 7'h07;
                            end
                        end
                        CMD_RCL:
                        begin
                            if (req_slot > TOP_SLOT ||
                                (req_slot >= low_slot &&
                                 low_slot != NUM_SLOTS))
                                nxt.err = ERR_RANGE_20;
                            else
                            begin
                                nxt.done = 1'b0;
                                nxt.rd_elem = 1'b0;
                                nxt.st = ST_RD;
                            end
                        end
                        // Mode check first: a stale sweep must not grow
                        CMD_ESTO:
                        begin
                            if (mode_changed)
                                nxt.err = ERR_SWEEP;
                            else if (req_elem > 7'(MAX_ELEM) ||
                                     req_elem > r.n_elem)
                                nxt.err = ERR_RANGE_23;
                            else
                            begin
                                e_we = 1'b1;
                                if (req_elem == r.n_elem)
                                    nxt.n_elem = r.n_elem + 7'h01;
                            end
                        end
                        CMD_ERCL:
                        begin
                            if (req_elem >= r.n_elem)
                                nxt.err = ERR_RANGE_20;
                            else
                            begin
                                nxt.done = 1'b0;
                                nxt.rd_elem = 1'b1;
                                nxt.st = ST_RD;
                            end
                        end
                        CMD_ECLR:
                        begin
                            // Freed slots get preset, one per cycle
                            nxt.done = 1'b0;
                            nxt.ptr = {3'h0, low_slot};
                            nxt.n_elem = '0;
                            nxt.clr_boot = 1'b0;
                            nxt.st = ST_CLR;
                        end
                        CMD_PRST:
                        begin
                            nxt.sload = 1'b1;
                            nxt.sout = PRESET_STATE;
                        end
                        default:
                            nxt.done = 1'b1;
                    endcase
                end
            end
            // Memory read latency
            ST_RD:
                nxt.st = ST_OUT;
            // Hand the read word to the current state or element
            ST_OUT:
            begin
                nxt.done = 1'b1;
                if (r.rd_elem)
                begin
                    nxt.eload = 1'b1;
                    nxt.eout = e_rd;
                end
                else
                begin
                    nxt.sload = 1'b1;
                    nxt.sout = s_rd;
                end
                nxt.st = ST_IDLE;
            end
        endcase
        // Hold read address through the read cycle
        if (r.st == ST_RD || r.st == ST_OUT)
        begin
            s_ra = r.ptr[3:0];
            e_ra = r.ptr[5:0];
        end
        // Latch the read pointer while idle; only a take makes use of it
        if (r.st == ST_IDLE)
            nxt.ptr = {3'h0, req_slot};
        if (r.st == ST_IDLE && req_cmd == CMD_ERCL)
            nxt.ptr = req_elem;
        if (r.st == ST_IDLE && req_cmd == CMD_ECLR)
            nxt.ptr = {3'h0, low_slot};
        if (r.st == ST_BOOT)
            nxt.ptr = '0;
    end

    // State register; storage itself is never reset
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r <= '0;
            r.st <= ST_INIT;
        end
        else
            r <= nxt;
    end

    assign done       = r.done;
    assign error_code = r.err;
    assign state_load = r.sload;
    assign state_out  = r.sout;
    assign elem_load  = r.eload;
    assign elem_out   = r.eout;
endmodule

// *** hw/ssr_pkg.sv ***
// Behaviour
// - Save writes current state into slot 0-9
// - Later save overwrites earlier slot contents
// - Power loss saves current state into slot 0
// - Save inside element region, not lowest: error 23
// - Save into lowest element slot reclaims it
// - Recall loads stored state from slot 0-9
// - Recall of element slot: error 20, unchanged
// - Shift held at power-up presets every slot
// - Switch selects slot 0 as power-on state
// - Element recall 00-62 loads A, B, time
// - Recall of unstored element: error 20
// - Element store 00-62 writes A, B, dwell
// - New elements sequential from 00, else 23
// - Element store after mode change: error 117
// - Seven elements per slot, from slot 9 downward
// - Element clear erases elements, presets their slots
// - Preset sets current state, keeps storage
package ssr_pkg;
    localparam int          STATE_W      = 64;
    localparam int          FREQ_W       = 32;
    localparam int          ELEM_W       = 3 * FREQ_W;
    localparam int          SLOT_AW      = 4;
    localparam int          ELEM_AW      = 6;
    localparam logic [3:0]  NUM_SLOTS    = 4'hA;
    localparam logic [3:0]  TOP_SLOT     = 4'h9;
    localparam logic [5:0]  ELEMS_SLOT   = 6'h07;
    localparam logic [5:0]  MAX_ELEM     = 6'h3E;
    localparam logic [6:0]  ELEM_COUNT_W = 7'h3F;
    localparam logic [STATE_W-1:0] PRESET_STATE = 64'h0000_0000_0000_0000;
    localparam logic [ELEM_W-1:0]  PRESET_ELEM  = '0;
    localparam logic [7:0]  ERR_NONE     = 8'h00;
    localparam logic [7:0]  ERR_RANGE_20 = 8'h14;
    localparam logic [7:0]  ERR_RANGE_23 = 8'h17;
    localparam logic [7:0]  ERR_SWEEP    = 8'h75;

    typedef enum logic [3:0]
    {
        CMD_SAVE  = 4'h1,
        CMD_RCL   = 4'h2,
        CMD_ESTO  = 4'h3,
        CMD_ERCL  = 4'h4,
        CMD_ECLR  = 4'h5,
        CMD_PRST  = 4'h6,
        CMD_PDOWN = 4'h7
    } ssr_cmd_t;
endpackage

// *** hw/ssr_mem.sv ***
`timescale 1ns/100ps
// Small synchronous memory with registered read data
module ssr_mem #(
    parameter int AW = 4,
    parameter int DW = 64,
    parameter int DEPTH = 10
) (
    input  wire logic          sys_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];

    // No reset: contents model nonvolatile storage
    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_data <= mem[rd_addr];
    end
endmodule

// *** hw/ssr_elem_map.sv ***
`timescale 1ns/100ps
// Maps an element index to its storage slot, seven per slot from the top
module ssr_elem_map
    import ssr_pkg::*;
(
    input  wire logic [ssr_pkg::ELEM_AW-1:0] elem_idx,
    output logic      [ssr_pkg::SLOT_AW-1:0] elem_slot
);
    import ssr_pkg::*;

    always_comb
    begin
        elem_slot = TOP_SLOT;
        for (int i = 1; i < 9; i++)
            if (elem_idx >= 6'(i * 7))
                elem_slot = TOP_SLOT - 4'(i);
    end
endmodule

// *** tb/ssr_checker.sv ***
`timescale 1ns/100ps
// Ties the answers of the core to the requests it takes
module ssr_checker
    import ssr_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              resetn,
    input wire logic              req_valid,
    input wire ssr_pkg::ssr_cmd_t req_cmd,
    input wire logic [6:0]        req_elem,
    input wire logic              mode_changed,
    input wire logic              req_ready,
    input wire logic              done,
    input wire logic [7:0]        error_code,
    input wire logic              state_load,
    input wire logic [63:0]       state_out,
    input wire logic              elem_load
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // A request counts only on an edge where both sides agree
    wire take = req_valid && req_ready;

    AST_SAVE_DONE: assert property (
        take && req_cmd == CMD_SAVE |=> done)
        else $error("save not answered next cycle");
    AST_RCL_ANSWER: assert property (
        take && req_cmd == CMD_RCL |->
            (##1 (done && error_code == ERR_RANGE_20)) or
            (##3 (done && state_load)))
        else $error("recall answer wrong");
    AST_ERCL_ANSWER: assert property (
        take && req_cmd == CMD_ERCL |->
            (##1 (done && error_code == ERR_RANGE_20)) or
            (##3 (done && elem_load)))
        else $error("element recall answer wrong");
    AST_PRESET_LOAD: assert property (
        take && req_cmd == CMD_PRST |=>
            done && state_load && state_out == PRESET_STATE)
        else $error("preset not loaded");
    AST_ESTO_MODE: assert property (
        take && req_cmd == CMD_ESTO && mode_changed |=>
            done && error_code == ERR_SWEEP)
        else $error("store after mode change not refused");
    AST_ESTO_RANGE: assert property (
        take && req_cmd == CMD_ESTO && !mode_changed &&
            req_elem > 7'h3E |=> done && error_code == ERR_RANGE_23)
        else $error("element index above range not refused");
    AST_ECLR_DONE: assert property (
        take && req_cmd == CMD_ECLR |-> ##[2:11] done)
        else $error("element clear not finished");
    AST_ERR_QUIET: assert property (
        done && error_code != ERR_NONE |-> !state_load && !elem_load)
        else $error("load beside an error");
    AST_ERR_HOLD: assert property (
        done && !take ##1 !take [*2] |-> $stable(error_code))
        else $error("error code moved without a request");

    C_CLEAR: cover property (take && req_cmd == CMD_ECLR);
    C_RANGE: cover property (done && error_code == ERR_RANGE_23);
    C_ELEM: cover property (elem_load);
endmodule

// *** tb/ssr_panel_model.sv ***
`timescale 1ns/100ps
// Keypad and remote parser stand-in: one request per go pulse
module ssr_panel_model
    import ssr_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic              go,
    input  wire ssr_pkg::ssr_cmd_t cmd,
    input  wire logic [3:0]        slot,
    input  wire logic [6:0]        elem,
    input  wire logic              req_ready,
    output logic                   req_valid,
    output ssr_pkg::ssr_cmd_t      req_cmd,
    output logic [3:0]             req_slot,
    output logic [6:0]             req_elem
);
    // Held until taken; indices pass as given, the bench orders them
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            req_valid <= 1'b0;
            req_cmd   <= CMD_PRST;
            req_slot  <= 4'h0;
            req_elem  <= 7'h00;
        end
        else if (go)
        begin
            req_valid <= 1'b1;
            req_cmd   <= cmd;
            req_slot  <= slot;
            req_elem  <= elem;
        end
        else if (req_valid && req_ready)
        begin
            req_valid <= 1'b0;
            req_slot  <= ~req_slot;  // Stale operands must not look valid
            req_elem  <= ~req_elem;
        end
    end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
    begin n_compared++; if ((got) !== (ex)) begin miscompares++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb;
    import ssr_pkg::*;
    logic sys_clk = 1'b0, resetn = 1'b0, go = 1'b0, mode_changed = 1'b0;
    logic shift_key = 1'b0, save_switch = 1'b0, g_sl, g_el;
    ssr_cmd_t cmd = CMD_PRST, req_cmd;
    logic [3:0] slot = 4'h0, req_slot;
    logic [6:0] elem = 7'h00, req_elem;
    logic [63:0] cur_state = 64'h0, state_out, g_st;
    logic [95:0] cur_elem = 96'h0, elem_out;
    logic [7:0] error_code, g_err;
    logic req_valid, req_ready, done, state_load, elem_load;
    int miscompares = 0, n_compared = 0, cyc = 0;

    // 20 MHz system clock
    always #25 sys_clk = ~sys_clk;

    ssr_panel_model u_panel (.sys_clk(sys_clk), .resetn(resetn), .go(go),
        .cmd(cmd), .slot(slot), .elem(elem), .req_ready(req_ready),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_slot(req_slot),
        .req_elem(req_elem));
    ssr_core DUT (.sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_slot(req_slot), .req_elem(req_elem),
        .cur_state_in(cur_state), .cur_elem_in(cur_elem),
        .mode_changed(mode_changed), .shift_key(shift_key),
        .save_switch(save_switch), .req_ready(req_ready), .done(done),
        .error_code(error_code), .state_load(state_load),
        .state_out(state_out), .elem_load(elem_load), .elem_out(elem_out));

    task automatic summarize();
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // A hang far past the expected run length counts as a mismatch
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            summarize();
        end
    end

    // Element payload unique per index, never equal to the preset element
    function automatic logic [95:0] ed(input logic [6:0] e);
        return {25'h1, e, 25'h2, e, 25'h3, e};
    endfunction

    task automatic ask(input ssr_cmd_t c, input logic [3:0] s,
                       input logic [6:0] e, input logic [63:0] st);
        logic ok;
        ok = 1'b0;
        @(posedge sys_clk);
        cmd <= c;
        slot <= s;
        elem <= e;
        cur_state <= st;
        cur_elem <= ed(e);
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        // Every request, element clear too, ends in one done pulse
        for (int i = 0; i < 80 && !ok; i++)
        begin
            @(negedge sys_clk);
            ok = (done === 1'b1);
        end
        `CHK("answer", 1'b1, ok)
        g_err = error_code;
        g_sl = state_load;
        g_el = elem_load;
        g_st = state_out;
    endtask

    task automatic reboot(input logic sh, input logic sw,
                          output logic [63:0] bs);
        logic ok;
        ok = 1'b0;
        bs = 'x;
        @(posedge sys_clk);
        resetn <= 1'b0;
        shift_key <= sh;
        save_switch <= sw;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 200 && !ok; i++)
        begin
            @(negedge sys_clk);
            if (state_load === 1'b1)
                bs = state_out;
            ok = (req_ready === 1'b1);
        end
        `CHK("boot", 1'b1, ok)
    endtask

    task automatic t_state();
        ask(CMD_SAVE, 4'h9, 7'h00, 64'h55);
        `CHK("save slot 9", ERR_NONE, g_err)
        ask(CMD_SAVE, 4'h3, 7'h00, 64'h51);
        `CHK("save err", ERR_NONE, g_err)
        ask(CMD_SAVE, 4'h3, 7'h00, 64'h52);
        ask(CMD_RCL, 4'h3, 7'h00, 64'h99);
        `CHK("recall load", 1'b1, g_sl)
        `CHK("recall state", 64'h52, g_st)
    endtask

    task automatic t_elems();
        ask(CMD_ESTO, 4'h0, 7'h00, 64'h0);
        `CHK("store 0", ERR_NONE, g_err)
        ask(CMD_ESTO, 4'h0, 7'h02, 64'h0);
        `CHK("store gap", ERR_RANGE_23, g_err)
        ask(CMD_ESTO, 4'h0, 7'h3F, 64'h0);
        `CHK("store 63", ERR_RANGE_23, g_err)
        @(posedge sys_clk);
        mode_changed <= 1'b1;
        ask(CMD_ESTO, 4'h0, 7'h01, 64'h0);
        `CHK("store mode", ERR_SWEEP, g_err)
        @(posedge sys_clk);
        mode_changed <= 1'b0;
        ask(CMD_ERCL, 4'h0, 7'h01, 64'h0);
        `CHK("null elem", ERR_RANGE_20, g_err)
        `CHK("null load", 1'b0, g_el)
        ask(CMD_ERCL, 4'h0, 7'h00, 64'h0);
        `CHK("elem 0", ed(7'h00), elem_out)
        ask(CMD_RCL, 4'h9, 7'h00, 64'h0);
        `CHK("recall elem slot", ERR_RANGE_20, g_err)
        `CHK("no state load", 1'b0, g_sl)
    endtask

    task automatic t_region();
        for (int i = 1; i < 8; i++)
            ask(CMD_ESTO, 4'h0, 7'(i), 64'h0);
        `CHK("store 7", ERR_NONE, g_err)
        ask(CMD_SAVE, 4'h9, 7'h00, 64'h53);
        `CHK("save inside", ERR_RANGE_23, g_err)
        ask(CMD_RCL, 4'h8, 7'h00, 64'h0);
        `CHK("slot 8 elems", ERR_RANGE_20, g_err)
        ask(CMD_SAVE, 4'h8, 7'h00, 64'h53);
        `CHK("save lowest", ERR_NONE, g_err)
        ask(CMD_RCL, 4'h8, 7'h00, 64'h0);
        `CHK("reclaimed", 64'h53, g_st)
        ask(CMD_ERCL, 4'h0, 7'h06, 64'h0);
        `CHK("elem 6", ed(7'h06), elem_out)
    endtask

    task automatic t_preset_clear();
        ask(CMD_PRST, 4'h0, 7'h00, 64'h0);
        `CHK("preset", PRESET_STATE, g_st)
        ask(CMD_RCL, 4'h3, 7'h00, 64'h0);
        `CHK("kept slot", 64'h52, g_st)
        ask(CMD_ECLR, 4'h0, 7'h00, 64'h0);
        `CHK("clear err", ERR_NONE, g_err)
        ask(CMD_ERCL, 4'h0, 7'h00, 64'h0);
        `CHK("cleared elem", ERR_RANGE_20, g_err)
        ask(CMD_RCL, 4'h9, 7'h00, 64'h0);
        `CHK("slot 9 preset", PRESET_STATE, g_st)
    endtask

    task automatic t_power();
        ask(CMD_PDOWN, 4'h0, 7'h00, 64'h54);
        reboot(1'b0, 1'b1, g_st);
        `CHK("power-on slot 0", 64'h54, g_st)
        reboot(1'b1, 1'b0, g_st);
        `CHK("boot preset", PRESET_STATE, g_st)
        ask(CMD_RCL, 4'h3, 7'h00, 64'h0);
        `CHK("memory clear", PRESET_STATE, g_st)
    endtask

    // Start from a cleared store, then walk the scenarios
    initial
    begin
        reboot(1'b1, 1'b0, g_st);
        t_state();
        t_elems();
        t_region();
        t_preset_clear();
        t_power();
        summarize();
    end
endmodule

bind ssr_core ssr_checker u_chk (.sys_clk(sys_clk), .resetn(resetn),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_elem(req_elem),
    .mode_changed(mode_changed), .req_ready(req_ready), .done(done),
    .error_code(error_code), .state_load(state_load),
    .state_out(state_out), .elem_load(elem_load));
